// *** logic/ftbs_port.sv ***
// Flow-through no-wait-state burst SRAM core with synchronous port
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Sleep and output enable gate the data pin drivers through synchronisers and a register.
// - Write-select low at the edge writes; high reads, lanes ignored.
// - x36: four lanes each gate one byte; all high aborts.
// - Strap high gives interleaved order: start XOR 01, 10, 11.
// - Strap low selects linear burst order.
// - Inputs stop being sampled within 2 cycles of sleep request.
// - Data pins stay high impedance from power-up until normal use.
// - Clock-gating high freezes the operation, address and burst registers and blocks writes.
// - Load low takes a new address; high advances the burst counter.
// - Writes self-time from the edge where write-select is low.
module ftbs_port (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic clk_en_i,
   input wire logic clk_gate_n_i,
   input wire logic [ftbs_pkg::ADDR_W-1:0] addr_i,
   input wire logic chip_sel_i,
   input wire logic load_or_advance_i,
   input wire logic write_sel_n_i,
   input wire logic [ftbs_pkg::LANES-1:0] byte_lane_write_n_i,
   input wire logic output_enable_n_i,
   input wire logic sleep_request_i,
   input wire logic burst_mode_i,
   input wire logic [ftbs_pkg::DATA_W-1:0] dq_i,
   output logic [ftbs_pkg::DATA_W-1:0] dq_o,
   output logic [ftbs_pkg::DATA_W-1:0] dq_oe_o,
   output logic sleeping_o
);
   localparam int unsigned AW = ftbs_pkg::ADDR_W;
   localparam int unsigned DW = ftbs_pkg::DATA_W;

   // Pin synchronisers: two flops before any logic looks at them
   logic [1:0] oe_n_sync_reg;
   logic [1:0] sleep_sync_reg;
   logic [1:0] mode_sync_reg;
   logic [1:0] gate_sync_reg;
   logic [1:0] sleep_cnt_reg;
   logic [1:0] sleep_cnt_next;

   logic [DW-1:0] mem [ftbs_pkg::DEPTH];
   logic [AW-1:0] base_addr_reg;
   logic [1:0] start_low_reg;
   logic [1:0] burst_cnt_reg;
   ftbs_pkg::ftbs_op_t op_reg;
   ftbs_pkg::ftbs_op_t op_next;
   logic [DW-1:0] dq_reg;
   logic [DW-1:0] dq_oe_reg;
   logic sleeping_reg;

   // Linear or interleaved next beat address
   function automatic logic [1:0] next_low(input logic [1:0] start,
                                           input logic [1:0] cnt,
                                           input logic interleaved);
      logic [1:0] step;
      step = cnt + ftbs_pkg::BURST_STEP;
      if (interleaved) begin
         next_low = start ^ step;
      end else begin
         next_low = start + step;
      end
   endfunction : next_low

   wire oe_n = oe_n_sync_reg[1];
   wire sleep_on = sleep_sync_reg[1];
   wire interleaved = (mode_sync_reg[1] == ftbs_pkg::MODE_INTERLEAVED);
   wire gated = gate_sync_reg[1];
   // Sleep ignores inputs once the synchronised request is seen
   wire sample_en = clk_en_i && !gated && !sleep_on;
   wire load = !load_or_advance_i;
   wire is_write = !write_sel_n_i;
   wire [1:0] adv_low = next_low(start_low_reg, burst_cnt_reg, interleaved);
   wire [1:0] cur_low = load ? addr_i[1:0] : adv_low;
   wire [AW-1:0] cur_addr = {(load ? addr_i[AW-1:2] : base_addr_reg[AW-1:2]),
                             cur_low};
   // Writes keep burst lane strobes; all lanes high means abort
   wire op_active = load ? chip_sel_i : (op_reg != ftbs_pkg::FTBS_IDLE);
   wire op_write = load ? is_write : (op_reg == ftbs_pkg::FTBS_WRITE);
   wire do_write = sample_en && op_active && op_write;
   wire do_read = op_active && !op_write;

   always_comb begin
      op_next = op_reg;
      if (load) begin
         if (!chip_sel_i) begin
            op_next = ftbs_pkg::FTBS_IDLE;
         end else if (is_write) begin
            op_next = ftbs_pkg::FTBS_WRITE;
         end else begin
            op_next = ftbs_pkg::FTBS_READ;
         end
      end
   end

   always_comb begin
      sleep_cnt_next = sleep_cnt_reg;
      if (!sleep_on) begin
         sleep_cnt_next = 2'h0;
      end else if (sleep_cnt_reg != ftbs_pkg::SLEEP_CNT_MAX) begin
         sleep_cnt_next = sleep_cnt_reg + 2'h1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         oe_n_sync_reg <= 2'h3;
         sleep_sync_reg <= 2'h0;
         mode_sync_reg <= 2'h3;
         gate_sync_reg <= 2'h0;
      end else if (clk_en_i) begin
         oe_n_sync_reg <= {oe_n_sync_reg[0], output_enable_n_i};
         sleep_sync_reg <= {sleep_sync_reg[0], sleep_request_i};
         mode_sync_reg <= {mode_sync_reg[0], burst_mode_i};
         gate_sync_reg <= {gate_sync_reg[0], clk_gate_n_i};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         op_reg <= ftbs_pkg::FTBS_IDLE;
         base_addr_reg <= '0;
         start_low_reg <= 2'h0;
         burst_cnt_reg <= 2'h0;
      end else if (sample_en) begin
         op_reg <= op_next;
         if (load) begin
            base_addr_reg <= addr_i;
            start_low_reg <= addr_i[1:0];
            burst_cnt_reg <= 2'h0;
         end else begin
            burst_cnt_reg <= burst_cnt_reg + ftbs_pkg::BURST_STEP;
         end
      end
   end

   // Lane mask merge keeps one writer on the array; high lanes keep bytes
   wire [DW-1:0] lane_mask;
   genvar g;
   generate
      for (g = 0; g < ftbs_pkg::LANES; g++) begin : g_lane
         assign lane_mask[g*ftbs_pkg::LANE_W +: ftbs_pkg::LANE_W] =
            {ftbs_pkg::LANE_W{!byte_lane_write_n_i[g]}};
      end
   endgenerate
   wire [DW-1:0] merged_word = (mem[cur_addr] & ~lane_mask) |
                               (dq_i & lane_mask);

   // Self-timed write on the sampling edge
   always_ff @(posedge ref_clk_i) begin
      if (do_write) begin
         mem[cur_addr] <= merged_word;
      end
   end

   // Read data leaves in the next cycle with no extra pipeline stage
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         dq_reg <= '0;
         dq_oe_reg <= '0;
         sleep_cnt_reg <= 2'h0;
         sleeping_reg <= 1'b0;
      end else if (clk_en_i) begin
         sleep_cnt_reg <= sleep_cnt_next;
         sleeping_reg <= sleep_on;
         if (sample_en && do_read) begin
            dq_reg <= mem[cur_addr];
         end
         dq_oe_reg <= {DW{sample_en && do_read && !oe_n}};
      end
   end

   assign dq_o = dq_reg;
   assign dq_oe_o = dq_oe_reg;
   assign sleeping_o = sleeping_reg;

   chk_sleep_hiz: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && sleep_on |=> dq_oe_o == '0)
      else $error("data driven during sleep");
   chk_write_hiz: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && do_write |=> dq_oe_o == '0)
      else $error("data driven on write");
   chk_oe_gate: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && oe_n |=> dq_oe_o == '0)
      else $error("data driven with output enable off");
   // Request seen two enabled edges ago must already block writes
   chk_sleep_ignore: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      $past(sleep_request_i, 2) && $past(clk_en_i, 2) && $past(clk_en_i)
      && !$past(srst_i, 2) && !$past(srst_i) |-> !do_write)
      else $error("write taken after sleep latency");
   chk_gate_freeze: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      gated |=> $stable(burst_cnt_reg) && $stable(base_addr_reg)
      && $stable(op_reg))
      else $error("state changed while gated");
   chk_burst_adv: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      sample_en && !load |=> burst_cnt_reg == $past(burst_cnt_reg) + 2'h1)
      else $error("burst counter did not advance");
   chk_load_addr: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      sample_en && load |=> base_addr_reg == $past(addr_i))
      else $error("address not loaded");
   chk_interleave: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      interleaved && !load |->
      cur_low == (start_low_reg ^ (burst_cnt_reg + 2'h1)))
      else $error("interleaved order wrong");
   chk_linear: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      !interleaved && !load |->
      cur_low == (start_low_reg + burst_cnt_reg + 2'h1))
      else $error("linear order wrong");
   chk_read_drive: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      sample_en && do_read && !oe_n |=> dq_oe_o == '1)
      else $error("read data not driven");

   cov_read: cover property (@(posedge ref_clk_i) sample_en && do_read);
   cov_write: cover property (@(posedge ref_clk_i) do_write);
   cov_burst: cover property (@(posedge ref_clk_i) sample_en && !load
      && burst_cnt_reg == 2'h2);
   cov_sleep: cover property (@(posedge ref_clk_i) sleep_cnt_reg == 2'h2);
endmodule : ftbs_port
`default_nettype wire

// *** logic/ftbs_pkg.sv ***
// Package: constants for the flow-through burst SRAM port
package ftbs_pkg;
   localparam int unsigned ADDR_W = 18;
   localparam int unsigned LANES = 4;
   localparam int unsigned LANE_W = 9;
   localparam int unsigned DATA_W = LANES * LANE_W;
   localparam int unsigned DEPTH = 1 << ADDR_W;
   localparam int unsigned BURST_W = 2;
   localparam logic [1:0] BURST_STEP = 2'h1;
   // Sleep entry and exit latency in cycles
   localparam int unsigned SLEEP_CYC = 2;
   localparam logic [1:0] SLEEP_CNT_MAX = 2'h2;
   // Mode strap level selecting interleaved order
   localparam logic MODE_INTERLEAVED = 1'b1;
   // Controller wait after power-up, in ns, and its cycle count at 100 MHz
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned POWER_WAIT_NS = 1000000;
   localparam int unsigned POWER_WAIT_CYC = POWER_WAIT_NS / CLK_PERIOD_NS;
   typedef enum logic [1:0] {
      FTBS_IDLE,
      FTBS_READ,
      FTBS_WRITE
   } ftbs_op_t;
endpackage : ftbs_pkg

// *** verification/ftbs_ctl_model.sv ***
// Controller model driving the port's synchronous inputs
`timescale 1ns/100ps
`default_nettype none
module ftbs_ctl_model (
   input wire logic clk_i,
   output logic cs_o,
   output logic ld_o,
   output logic wsel_n_o,
   output logic oe_n_o,
   output logic [3:0] bw_n_o,
   output logic [17:0] addr_o,
   output logic [35:0] dq_o
);
   initial begin
      cs_o = 1'b0;
      ld_o = 1'b0;
      wsel_n_o = 1'b1;
      oe_n_o = 1'b1;
      bw_n_o = 4'hf;
      addr_o = 18'h0;
      dq_o = 36'h0;
   end
   task automatic issue(input logic c, l, w, o, input logic [3:0] b,
         input logic [17:0] a, input logic [35:0] d);
      @(posedge clk_i);
      cs_o <= c;
      ld_o <= l;
      wsel_n_o <= w;
      oe_n_o <= o;
      bw_n_o <= b;
      addr_o <= a;
      // Data not written is scrambled so stale values never match
      dq_o <= w ? ~dq_o : d;
   endtask : issue
   task automatic idle(input int n, input logic o);
      // Always a full deselect, never a bare continue-deselect
      repeat (n) issue(1'b0, 1'b0, 1'b1, o, 4'hf, 18'h0, 36'h0);
   endtask : idle
endmodule : ftbs_ctl_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the burst SRAM port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic ref_clk_i, srst_i, clk_en_i, clk_gate_n_i, chip_sel_i;
   logic load_or_advance_i, write_sel_n_i, output_enable_n_i;
   logic sleep_request_i, burst_mode_i, sleeping_o;
   logic [3:0] byte_lane_write_n_i;
   logic [17:0] addr_i;
   logic [35:0] dq_i, dq_o, dq_oe_o;
   int fails = 0;
   int total_checks = 0;
   localparam logic [17:0] B = 18'h00100;
   localparam logic [17:0] G = 18'h00200;
   ftbs_port dut (.ref_clk_i, .srst_i, .clk_en_i, .clk_gate_n_i, .addr_i,
      .chip_sel_i, .load_or_advance_i, .write_sel_n_i,
      .byte_lane_write_n_i, .output_enable_n_i, .sleep_request_i,
      .burst_mode_i, .dq_i, .dq_o, .dq_oe_o, .sleeping_o);
   ftbs_ctl_model u_ctl (.clk_i(ref_clk_i), .cs_o(chip_sel_i),
      .ld_o(load_or_advance_i), .wsel_n_o(write_sel_n_i),
      .oe_n_o(output_enable_n_i), .bw_n_o(byte_lane_write_n_i),
      .addr_o(addr_i), .dq_o(dq_i));
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   function automatic logic [35:0] pat(input logic [17:0] a);
      return {a ^ 18'h2a5a5, a};
   endfunction : pat
   task automatic chk(input string n, input logic [35:0] s, e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict
   task automatic wr(input logic [17:0] a, input logic [3:0] b,
         input logic [35:0] d);
      u_ctl.issue(1'b1, 1'b0, 1'b0, 1'b1, b, a, d);
   endtask : wr
   task automatic rd(input logic [17:0] a, input logic l);
      // Lanes held low on reads must not write
      u_ctl.issue(1'b1, l, 1'b1, 1'b0, 4'h0, a, 36'h0);
   endtask : rd
   task automatic t_lanes();
      for (int l = 0; l < 5; l++) begin
         wr(B + 18'(l), 4'h0, pat(B + 18'(l)));
         wr(B + 18'(l), ~(4'h1 << l), 36'h0);
      end
      u_ctl.idle(3, 1'b0);
      for (int l = 0; l < 6; l++) begin
         if (l < 5) rd(B + 18'(l), 1'b0);
         else u_ctl.idle(1, 1'b0);
         if (l > 0) begin
            #1;
            chk("lane data", dq_o,
               pat(B + 18'(l - 1)) & ~(36'h1ff << (9 * (l - 1))));
            chk("read drive", dq_oe_o, {36{1'b1}});
         end
      end
      $display("lanes test done");
   endtask : t_lanes
   task automatic t_oe();
      u_ctl.idle(3, 1'b1);
      u_ctl.issue(1'b1, 1'b0, 1'b1, 1'b1, 4'hf, B, 36'h0);
      // Look in the cycle the read answers, while the enable is still off
      u_ctl.idle(1, 1'b1);
      #1;
      chk("disabled drive", dq_oe_o, 36'h0);
      $display("output enable test done");
   endtask : t_oe
   task automatic t_hold(input int k);
      // k selects the hold source: 0 sleep, 1 gating pin, 2 clock enable
      @(posedge ref_clk_i);
      sleep_request_i <= (k == 0);
      clk_gate_n_i <= (k == 1);
      clk_en_i <= (k != 2);
      u_ctl.idle(4, 1'b1);
      wr(B + 18'h4, 4'h0, 36'h0);
      u_ctl.idle(1, 1'b1);
      #1;
      chk("sleep flag", {35'h0, sleeping_o}, {35'h0, 1'(k == 0)});
      @(posedge ref_clk_i);
      clk_gate_n_i <= 1'b0;
      sleep_request_i <= 1'b0;
      clk_en_i <= 1'b1;
      u_ctl.idle(4, 1'b0);
      rd(B + 18'h4, 1'b0);
      u_ctl.idle(1, 1'b0);
      #1;
      chk("held data", dq_o, pat(B + 18'h4));
      $display("hold test done");
   endtask : t_hold
   task automatic t_burst(input logic m);
      logic [1:0] b;
      @(posedge ref_clk_i);
      // Strap only moves under reset
      srst_i <= 1'b1;
      burst_mode_i <= m;
      repeat (6) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      for (int l = 0; l < 4; l++) wr(G + 18'(l), 4'h0, pat(G + 18'(l)));
      u_ctl.idle(3, 1'b0);
      for (int s = 0; s < 4; s++) begin
         for (int n = 0; n < 5; n++) begin
            if (n < 4) rd(G + 18'(s), n > 0);
            else u_ctl.idle(1, 1'b0);
            if (n > 0) begin
               b = m ? 2'(s) ^ 2'(n - 1) : 2'(s + n - 1);
               #1;
               chk("burst beat", dq_o, pat(G + 18'(b)));
            end
         end
      end
      $display("burst test done");
   endtask : t_burst
   initial begin
      // Time zero stands for a supply already past its power-up wait
      srst_i = 1'b1;
      clk_en_i = 1'b1;
      clk_gate_n_i = 1'b0;
      sleep_request_i = 1'b0;
      burst_mode_i = 1'b1;
      repeat (6) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      t_lanes();
      t_oe();
      t_hold(0);
      t_hold(1);
      t_hold(2);
      t_burst(1'b1);
      t_burst(1'b0);
      give_verdict();
   end
   initial begin
      #100000;
      fails++;
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
